/* File: rtl/power_unit_regs.svh */
// Purpose: register offsets, field positions and counts of the power unit
// Assumes: AXI4-Lite byte addresses, one aligned word per register
// Notes:   definitions only
`ifndef POWER_UNIT_REGS_SVH
`define POWER_UNIT_REGS_SVH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define WAKE_CONFIG_OFFS   12'h000
`define MODE_OFFS          12'h004
`define SUPPLY_CFG_OFFS    12'h008
`define STATUS_OFFS        12'h00c

// ----------------------------------------------------------------
// Wake config fields
// ----------------------------------------------------------------
`define WK_SLEEP_BIT       7
`define WK_SUSPEND_BIT     6
`define WK_CLEAR_BIT       5
`define WK_PINFLAG_BIT     4
// Mode register fields
`define MD_CLKOUT_BIT      7
`define MD_WAKEOE_BIT      6
`define MD_BATTERY_MONITOR_DISABLE_BIT      5
// Supply config fields
`define SC_FLOAT_BIT       1
`define SC_TWOCELL_BIT     0

// ----------------------------------------------------------------
// Reset values, timing and response codes
// ----------------------------------------------------------------
`define MODE_RESET         8'h00
`define FLAG_BLANK_CYCLES  2'h2
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

/* File: rtl/power_unit_pkg.sv */
// Purpose: types of the power unit
// Assumes: nothing
// Notes:   constants live in power_unit_regs.svh
package power_unit_pkg;

  typedef enum logic [1:0] {
    st_run,
    st_suspend,
    st_sleep,
    st_blank
  } power_state_t;

  // Order: osc fail, alarm, port match, comparator
  typedef struct packed {
    logic osc_fail;
    logic alarm;
    logic port_match;
    logic comp_rise;
  } wake_src_t;

  typedef struct packed {
    logic        aw_done;
    logic [11:0] aw_addr;
    logic        w_done;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } bus_state_t;

  typedef struct packed {
    power_state_t pstate;
    logic [1:0]   blank_cnt;
    wake_src_t    enables;
    wake_src_t    flags;
    logic         pin_flag;
    logic [7:0]   mode;
    logic         float_sel;
    logic         two_cell;
    logic         monitor_off;
    logic         por_req;
    logic [1:0]   pin_sync;
    logic         pin_last;
    wake_src_t    ev_sync1;
    wake_src_t    ev_sync2;
    wake_src_t    ev_last;
    bus_state_t   bus;
  } unit_state_t;

endpackage : power_unit_pkg

/* File: rtl/suspend_sleep_power_unit.sv */
// Purpose: suspend and sleep control, wake sources and wake flags
// Assumes: software keeps its own entry rules; events are async levels
// Notes:   one clock, AXI4-Lite register slave
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "power_unit_regs.svh"

module suspend_sleep_power_unit (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        reset_pin_n,
  input  wire logic        osc_fail_evt,
  input  wire logic        alarm_evt,
  input  wire logic        port_match_evt,
  input  wire logic        comp_level,
  output logic             sys_clk_gate,
  output logic             osc_disable,
  output logic             cpu_halt,
  output logic             core_regulator_off,
  output logic             ram_on_battery,
  output logic             pin_hold,
  output logic             port_match_live,
  output logic             analog_supply_rail_float,
  output logic             wake_request,
  output logic             battery_monitor_disable,
  output logic             por_request
);

  power_unit_pkg::unit_state_t st;
  power_unit_pkg::unit_state_t next_st;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic any_enabled_flag(input power_unit_pkg::wake_src_t en,
                                            input power_unit_pkg::wake_src_t fl);
    any_enabled_flag = |(en & fl);
  endfunction : any_enabled_flag

  function automatic logic low_power(input power_unit_pkg::power_state_t s);
    low_power = (s == power_unit_pkg::st_suspend) || (s == power_unit_pkg::st_sleep);
  endfunction : low_power

  logic                      wr_go;
  logic                      rd_go;
  logic                      wr_hit;
  logic                      rd_hit;
  logic                      pin_fall;
  power_unit_pkg::wake_src_t ev_rise;
  power_unit_pkg::wake_src_t wake_src;
  logic                      wake_now;
  logic [7:0]                wcfg_wr;
  logic [7:0]                flag_read;

  assign s_axi_awready = !st.bus.aw_done && !st.bus.bvalid;
  assign s_axi_wready  = !st.bus.w_done && !st.bus.bvalid;
  assign s_axi_arready = !st.bus.rvalid;
  assign wr_go = (st.bus.aw_done || s_axi_awvalid) && (st.bus.w_done || s_axi_wvalid) && !st.bus.bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [11:0] waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    next_st   = st;
    waddr     = st.bus.aw_done ? st.bus.aw_addr : s_axi_awaddr;
    wdata     = st.bus.w_done ? st.bus.w_data : s_axi_wdata;
    wstrb     = st.bus.w_done ? st.bus.w_strb : s_axi_wstrb;
    wr_hit    = 1'b0;
    rd_hit    = 1'b0;
    wcfg_wr   = wdata[7:0];
    flag_read = 8'h00;

    // Event synchronisers and edges
    next_st.pin_sync = {st.pin_sync[0], reset_pin_n};
    next_st.pin_last = st.pin_sync[1];
    pin_fall = st.pin_last && !st.pin_sync[1];
    next_st.ev_sync1 = {osc_fail_evt, alarm_evt, port_match_evt, comp_level};
    next_st.ev_sync2 = st.ev_sync1;
    next_st.ev_last  = st.ev_sync2;
    ev_rise = st.ev_sync2 & ~st.ev_last;

    next_st.flags    = st.flags | ev_rise;
    next_st.pin_flag = st.pin_flag | pin_fall;

    wake_src = st.enables & ev_rise;
    if (st.pstate == power_unit_pkg::st_sleep && !st.two_cell)
    begin
      wake_src.comp_rise = 1'b0;
    end
    wake_now = (|wake_src) || pin_fall;

    case (st.pstate)
      power_unit_pkg::st_run:
      begin
        next_st.pstate = power_unit_pkg::st_run;
      end
      power_unit_pkg::st_suspend:
      begin
        if (wake_now)
        begin
          next_st.pstate    = power_unit_pkg::st_blank;
          next_st.blank_cnt = `FLAG_BLANK_CYCLES;
        end
      end
      power_unit_pkg::st_sleep:
      begin
        if (wake_now)
        begin
          next_st.pstate = power_unit_pkg::st_run;
        end
      end
      power_unit_pkg::st_blank:
      begin
        next_st.blank_cnt = st.blank_cnt - 2'h1;
        if (st.blank_cnt == 2'h1)
        begin
          next_st.pstate = power_unit_pkg::st_run;
        end
      end
      default:
      begin
        next_st.pstate = power_unit_pkg::st_run;
      end
    endcase

    // Write channel capture
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_st.bus.aw_done = 1'b1;
      next_st.bus.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_st.bus.w_done = 1'b1;
      next_st.bus.w_data = s_axi_wdata;
      next_st.bus.w_strb = s_axi_wstrb;
    end

    if (wr_go)
    begin
      next_st.bus.aw_done = 1'b0;
      next_st.bus.w_done  = 1'b0;
      next_st.bus.bvalid  = 1'b1;
      case (waddr)
        `WAKE_CONFIG_OFFS:
        begin
          wr_hit = 1'b1;
          if (wstrb[0])
          begin
            // enables come with the entry write
            next_st.enables = wcfg_wr[3:0];
            // clear all flags; a same-cycle event still lands
            if (wcfg_wr[`WK_CLEAR_BIT])
            begin
              next_st.flags    = ev_rise;
              next_st.pin_flag = pin_fall;
            end
            // refuse entry on pending enabled flag
            if (st.pstate == power_unit_pkg::st_run &&
                !any_enabled_flag(wcfg_wr[3:0], next_st.flags) && !next_st.pin_flag && !wake_now)
            begin
              if (wcfg_wr[`WK_SLEEP_BIT])
              begin
                next_st.pstate = power_unit_pkg::st_sleep;
              end
              else if (wcfg_wr[`WK_SUSPEND_BIT])
              begin
                next_st.pstate = power_unit_pkg::st_suspend;
              end
            end
          end
        end
        `MODE_OFFS:
        begin
          wr_hit = 1'b1;
          if (wstrb[0])
          begin
            next_st.mode = {wdata[7:5], 5'h00};
            // set disables, clear while off asks POR
            if (wdata[`MD_BATTERY_MONITOR_DISABLE_BIT])
            begin
              next_st.monitor_off = 1'b1;
            end
            else if (st.monitor_off)
            begin
              next_st.por_req = 1'b1;
            end
          end
        end
        `SUPPLY_CFG_OFFS:
        begin
          wr_hit = 1'b1;
          if (wstrb[0])
          begin
            next_st.float_sel = wdata[`SC_FLOAT_BIT];
            next_st.two_cell  = wdata[`SC_TWOCELL_BIT];
          end
        end
        `STATUS_OFFS:
        begin
          wr_hit = 1'b1;
        end
        default:
        begin
          wr_hit = 1'b0;
        end
      endcase
      next_st.bus.bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (st.bus.bvalid && s_axi_bready)
    begin
      next_st.bus.bvalid = 1'b0;
    end

    flag_read = (st.pstate == power_unit_pkg::st_blank) ? 8'h00 :
                {3'h0, st.pin_flag, st.flags};
    if (rd_go)
    begin
      next_st.bus.rvalid = 1'b1;
      rd_hit = 1'b1;
      case (s_axi_araddr)
        `WAKE_CONFIG_OFFS: next_st.bus.rdata = {24'h0, flag_read};
        `MODE_OFFS:        next_st.bus.rdata = {24'h0, st.mode};
        `SUPPLY_CFG_OFFS:  next_st.bus.rdata = {30'h0, st.float_sel, st.two_cell};
        `STATUS_OFFS:      next_st.bus.rdata = {26'h0, st.por_req, st.monitor_off, st.enables};
        default:
        begin
          rd_hit = 1'b0;
          next_st.bus.rdata = 32'h0;
        end
      endcase
      next_st.bus.rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (st.bus.rvalid && s_axi_rready)
    begin
      next_st.bus.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st        <= '0;
      st.mode   <= `MODE_RESET;
      st.pstate <= power_unit_pkg::st_run;
      // Idle pin and levels assumed high/low at reset
      st.pin_sync <= 2'h3;
      st.pin_last <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_bvalid = st.bus.bvalid;
  assign s_axi_bresp  = st.bus.bresp;
  assign s_axi_rvalid = st.bus.rvalid;
  assign s_axi_rdata  = st.bus.rdata;
  assign s_axi_rresp  = st.bus.rresp;

  // clock and oscillators off in both states
  assign sys_clk_gate = low_power(st.pstate);
  assign osc_disable  = low_power(st.pstate);
  assign cpu_halt = low_power(st.pstate);
  assign core_regulator_off = (st.pstate == power_unit_pkg::st_sleep);
  assign ram_on_battery     = (st.pstate == power_unit_pkg::st_sleep);
  assign pin_hold = (st.pstate == power_unit_pkg::st_sleep);
  assign port_match_live = 1'b1;
  assign analog_supply_rail_float = (st.pstate == power_unit_pkg::st_sleep) && st.float_sel && !st.two_cell;
  // wake request, gated by its enable
  assign wake_request = st.mode[`MD_WAKEOE_BIT] && (st.pstate != power_unit_pkg::st_sleep);
  assign battery_monitor_disable = st.monitor_off;
  assign por_request             = st.por_req;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic wstrb_clear;
  assign wstrb_clear = (st.bus.w_done ? st.bus.w_strb[0] && st.bus.w_data[`WK_CLEAR_BIT]
                                      : s_axi_wstrb[0] && s_axi_wdata[`WK_CLEAR_BIT]);

  sequence entry_write_s;
    wr_go && wr_hit && (st.bus.aw_done ? st.bus.aw_addr : s_axi_awaddr) == `WAKE_CONFIG_OFFS;
  endsequence

  blank_flags_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.pstate == power_unit_pkg::st_suspend && wake_now) |=> (flag_read == 8'h00)[*2])
    else $error("flags not blanked after suspend");
  pin_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (low_power(st.pstate) && pin_fall) |=> !low_power(st.pstate))
    else $error("pin edge did not wake");
  refuse_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.pstate == power_unit_pkg::st_run &&
     (any_enabled_flag(next_st.enables, next_st.flags) || next_st.pin_flag))
    |=> st.pstate == power_unit_pkg::st_run)
    else $error("entered with enabled flag set");
  flag_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_rise.alarm |=> st.flags.alarm)
    else $error("event not recorded");
  clear_all_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (entry_write_s ##0 wstrb_clear) |=> ({st.pin_flag, st.flags} == {$past(pin_fall), $past(ev_rise)}))
    else $error("clear left flags");
  comp_sleep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.pstate == power_unit_pkg::st_sleep && !st.two_cell && ev_rise == 4'h1 && !pin_fall)
    |=> st.pstate == power_unit_pkg::st_sleep)
    else $error("comparator woke one-cell sleep");
  wake_req_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.pstate == power_unit_pkg::st_sleep) |-> !wake_request)
    else $error("wake request high asleep");
  sleep_power_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(st.pstate == power_unit_pkg::st_sleep) |-> core_regulator_off && ram_on_battery && sys_clk_gate)
    else $error("sleep power not cut");
  monitor_por_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(st.por_req) |-> $past(st.monitor_off))
    else $error("POR without monitor off");

endmodule : suspend_sleep_power_unit

/* File: verif/wake_follower_model.sv */
// Purpose: external supply that follows the wake request
// Assumes: request high means the system runs
// Notes:   settles SETTLE cycles after each change, like a slow converter
`timescale 1ns/100ps

module wake_follower_model #(
  parameter int SETTLE = 3
) (
  input  wire logic  aclk,
  input  wire logic  aresetn,
  input  wire logic  wake_request,
  output logic       ext_awake,
  output logic [7:0] wake_count
);
  int unsigned cnt;

  // ----------------------------------------
  // Follower
  // ----------------------------------------
  // track request level
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt        <= 0;
      ext_awake  <= 1'b0;
      wake_count <= 8'h00;
    end
    else if (wake_request == ext_awake)
      cnt <= 0;
    else if (cnt == SETTLE - 1)
    begin
      cnt        <= 0;
      ext_awake  <= wake_request;
      wake_count <= wake_count + {7'h00, wake_request};
    end
    else
      cnt <= cnt + 1;
  end
endmodule : wake_follower_model

/* File: verif/suspend_sleep_power_unit_tb.sv */
// Purpose: self-checking bench of the suspend and sleep power unit
// Assumes: event inputs held until the wake is seen
// Notes:   handshakes sampled at the falling edge, driven after the rising one
`timescale 1ns/100ps
`include "power_unit_regs.svh"

module suspend_sleep_power_unit_tb;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, rst_pin_n;
  logic        clk_gate, osc_off, halt, reg_off, ram_bat, pin_hold, pm_live;
  logic        rail_float, wake_req, mon_dis, por_req, ext_awake;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, evt;
  logic [1:0]  bresp, rresp;
  logic [7:0]  wake_count;
  int          miscompares, n_checks;
  // 15 us at 100 MHz
  localparam int PIN_WAKE_HOLD = 1500;

  suspend_sleep_power_unit dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .reset_pin_n(rst_pin_n), .osc_fail_evt(evt[3]), .alarm_evt(evt[2]),
    .port_match_evt(evt[1]), .comp_level(evt[0]), .sys_clk_gate(clk_gate),
    .osc_disable(osc_off), .cpu_halt(halt), .core_regulator_off(reg_off),
    .ram_on_battery(ram_bat), .pin_hold(pin_hold), .port_match_live(pm_live),
    .analog_supply_rail_float(rail_float), .wake_request(wake_req),
    .battery_monitor_disable(mon_dis), .por_request(por_req));

  wake_follower_model partner (.aclk(aclk), .aresetn(aresetn), .wake_request(wake_req),
    .ext_awake(ext_awake), .wake_count(wake_count));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic a_hs, w_hs, b_hs;
    logic [1:0] resp;
    int   n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(negedge aclk);
      a_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (a_hs)
        awvalid <= 1'b0;
      if (w_hs)
        wvalid <= 1'b0;
      n++;
    end while (!b_hs && n < 50);
    bready <= 1'b0;
    chk("write response", 1, b_hs);
    chk("write resp code", `RESP_OKAY, resp);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs, v;
    int   n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(negedge aclk);
      ar_hs = arvalid && arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_hs)
        arvalid <= 1'b0;
      n++;
    end while (!v && n < 50);
    rready <= 1'b0;
    chk("read response", 1, v);
  endtask : rd

  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string what);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(what, e, d & m);
  endtask : rdchk

  // Bounded wait, returns early once the halt drops
  task automatic wait_wake;
    int n;
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end while (halt === 1'b1 && n < 20);
  endtask : wait_wake

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    chk("clock gate at reset", 0, clk_gate);
    chk("port match live", 1, pm_live);
    rdchk(`MODE_OFFS, 32'hff, 32'h00, "mode reset");
    rd(12'h010, d, r);
    chk("unmapped resp", `RESP_SLVERR, r);
    chk("unmapped data", 0, d);
  endtask : t_reset

  task automatic t_flags;
    @(posedge aclk);
    evt[2] <= 1'b1;
    // Events reach the flags three cycles after they are driven
    repeat (6) @(posedge aclk);
    evt[2] <= 1'b0;
    rdchk(`WAKE_CONFIG_OFFS, 32'h1f, 32'h04, "disabled alarm flag");
    wr(`WAKE_CONFIG_OFFS, 8'h44);
    @(negedge aclk);
    chk("entry with flag set", 0, halt);
    wr(`WAKE_CONFIG_OFFS, 8'h20);
    rdchk(`WAKE_CONFIG_OFFS, 32'h1f, 32'h00, "flags cleared");
  endtask : t_flags

  task automatic t_sources;
    for (int i = 0; i < 4; i++)
    begin
      wr(`WAKE_CONFIG_OFFS, 8'h20);
      wr(`WAKE_CONFIG_OFFS, 8'h40 | (8'h01 << i));
      @(negedge aclk);
      chk("clock gated", 1, clk_gate);
      chk("oscillators off", 1, osc_off);
      chk("cpu halted", 1, halt);
      @(posedge aclk);
      evt[i] <= 1'b1;
      wait_wake;
      chk("source wake", 0, halt);
      @(posedge aclk);
      evt[i] <= 1'b0;
      rdchk(`WAKE_CONFIG_OFFS, 32'h0f, 32'h01 << i, "wake flag");
    end
  endtask : t_sources

  task automatic t_sleep;
    wr(`SUPPLY_CFG_OFFS, 8'h02);
    wr(`MODE_OFFS, 8'h40);
    repeat (6) @(posedge aclk);
    chk("far side awake", 1, ext_awake);
    wr(`WAKE_CONFIG_OFFS, 8'h20);
    wr(`WAKE_CONFIG_OFFS, 8'h81);
    @(negedge aclk);
    chk("regulator off", 1, reg_off);
    chk("ram on battery", 1, ram_bat);
    chk("pins held", 1, pin_hold);
    chk("rail floats", 1, rail_float);
    chk("request low asleep", 0, wake_req);
    @(posedge aclk);
    evt[0] <= 1'b1;
    wait_wake;
    chk("comparator one cell", 1, halt);
    @(posedge aclk);
    rst_pin_n <= 1'b0;
    wait_wake;
    chk("pin wake", 0, halt);
    @(posedge aclk);
    rst_pin_n <= 1'b1;
    evt[0]    <= 1'b0;
    rdchk(`WAKE_CONFIG_OFFS, 32'h10, 32'h10, "pin flag");
    repeat (6) @(posedge aclk);
    chk("wake count", 2, wake_count);
    repeat (PIN_WAKE_HOLD) @(posedge aclk);
    wr(`WAKE_CONFIG_OFFS, 8'h80);
    @(negedge aclk);
    chk("entry with pin flag", 0, halt);
    wr(`SUPPLY_CFG_OFFS, 8'h03);
    wr(`WAKE_CONFIG_OFFS, 8'h20);
    wr(`WAKE_CONFIG_OFFS, 8'h81);
    @(negedge aclk);
    chk("rail two cell", 0, rail_float);
    @(posedge aclk);
    evt[0] <= 1'b1;
    wait_wake;
    chk("comparator two cell", 0, halt);
    @(posedge aclk);
    evt[0] <= 1'b0;
  endtask : t_sleep

  task automatic t_monitor;
    rdchk(`MODE_OFFS, 32'hff, 32'h40, "mode readback");
    wr(`MODE_OFFS, 8'h60);
    @(negedge aclk);
    chk("monitor off", 1, mon_dis);
    rdchk(`STATUS_OFFS, 32'h30, 32'h10, "status monitor");
    wr(`MODE_OFFS, 8'h40);
    @(negedge aclk);
    chk("por request", 1, por_req);
  endtask : t_monitor

  task automatic test_done;
    $display("Checks %0d, miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // ----------------------------------------
  // Clock, watchdog, main
  // ----------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial
  begin
    repeat (5000) @(posedge aclk);
    miscompares++;
    test_done;
  end

  initial
  begin
    aresetn   = 1'b0;
    awaddr    = 12'h000;
    awvalid   = 1'b0;
    wdata     = 32'h0;
    wstrb     = 4'h0;
    wvalid    = 1'b0;
    bready    = 1'b0;
    araddr    = 12'h000;
    arvalid   = 1'b0;
    rready    = 1'b0;
    rst_pin_n = 1'b1;
    evt       = 4'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_flags;
    t_sources;
    t_sleep;
    t_monitor;
    test_done;
  end
endmodule : suspend_sleep_power_unit_tb
